// ===== common/mrs_regs.svh
// Constants for the serial register-protocol slave engine
`ifndef MRS_REGS_SVH
`define MRS_REGS_SVH

// ----------------------------------------
// Function and error codes
// ----------------------------------------
`define MRS_FN_READ      8'h03
`define MRS_FN_WR1       8'h06
`define MRS_FN_WRN       8'h10
`define MRS_EXC_NONE     8'h00
`define MRS_EXC_FUNC     8'h01
`define MRS_EXC_ADDR     8'h02
`define MRS_EXC_DATA     8'h03
`define MRS_EXC_BUSY     8'h06
`define MRS_BCAST        8'h00

// ----------------------------------------
// Reset values and limits
// ----------------------------------------
`define MRS_ADDR_RST     8'h01
`define MRS_BAUD_RST     3'h2
`define MRS_FMT_RST      2'h0
`define MRS_FMT_8N1      2'h3
`define MRS_DLY_RST      7'h00
`define MRS_DLY_MAX      7'h64
`define MRS_MAX_REGS     16'h007F
`define MRS_BUF_DEPTH    9'h108
`define MRS_LEN_MIN      9'h004
`define MRS_LEN_FIX      9'h008
`define MRS_LEN_WRN_HDR  9'h009
`define MRS_LEN_EXC      9'h003
`define MRS_LEN_ECHO     9'h006
`define MRS_RANGE_TOP    17'h1_0000

// ----------------------------------------
// CRC
// ----------------------------------------
`define MRS_CRC_POLY     16'hA001
`define MRS_CRC_INIT     16'hFFFF

// ----------------------------------------
// Timing
// ----------------------------------------
`define MRS_CLK_HZ        250000000
`define MRS_CLK_PERIOD_NS 4
`define MRS_DLY_UNIT_NS   1000000
`define MRS_DLY_UNIT_CYC  (`MRS_DLY_UNIT_NS / `MRS_CLK_PERIOD_NS)
`define MRS_SIL_HALF_10   7'h46
`define MRS_SIL_HALF_11   7'h4D
`define MRS_BAUD_0        2400
`define MRS_BAUD_1        4800
`define MRS_BAUD_2        9600
`define MRS_BAUD_3        19200
`define MRS_BAUD_4        38400
`define MRS_BAUD_5        57600
`define MRS_BAUD_6        115200
`define MRS_BAUD_7        25600

`endif

// ===== common/mrs_pkg.sv
// Types for the serial register-protocol slave engine
package mrs_pkg;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_CHECK = 3'b001,
    ST_EXEC  = 3'b010,
    ST_WAIT  = 3'b011,
    ST_DELAY = 3'b100,
    ST_TXLD  = 3'b101,
    ST_TX    = 3'b110
  } mrs_state_t;

  typedef enum logic [1:0] {
    RS_OK   = 2'b00,
    RS_ADDR = 2'b01,
    RS_DATA = 2'b10,
    RS_BUSY = 2'b11
  } mrs_status_t;

endpackage

// ===== design/mrs_crc16.sv
// Byte-serial CRC-16 accumulator, reflected form
`timescale 1ns/10ps
`include "mrs_regs.svh"

module mrs_crc16
  import mrs_pkg::*;
(
  input  wire logic        clk,    // System clock
  input  wire logic        reset,  // Async reset, high
  input  wire logic        init,   // Restart from initial value
  input  wire logic        en,     // Fold in one byte
  input  wire logic [7:0]  data,   // Byte to fold
  output logic      [15:0] crc_ff  // Running CRC
);

  function automatic logic [15:0] crc_byte(input logic [15:0] c, input logic [7:0] d);
    logic [15:0] r;
    r = c ^ {8'h00, d};
    for (int i = 0; i < 8; i++)
      r = r[0] ? ((r >> 1) ^ `MRS_CRC_POLY) : (r >> 1);
    crc_byte = r;
  endfunction

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      crc_ff <= `MRS_CRC_INIT;
    else if (en)
      crc_ff <= crc_byte(init ? `MRS_CRC_INIT : crc_ff, data);
    else if (init)
      crc_ff <= `MRS_CRC_INIT;
  end

endmodule

// ===== design/mrs_engine.sv
// Serial register-protocol slave engine: framing, checks, register access, replies
`timescale 1ns/10ps
`include "mrs_regs.svh"

// Operation
// - Act only on frames addressed to own address or broadcast
// - Reply address byte repeats the request address
// - Own address is a programmable full-range byte
// - Broadcast requests execute but never get any reply
// - Support read (3), write single (6), write multiple (16)
// - Values, addresses and counts go high byte first
// - Read reply: address, function, byte count twice registers, values, CRC
// - Single write reply echoes the request byte for byte
// - Multiple write reply: address, function, start, count, new CRC
// - Frame ends after three and a half character times of silence
// - After silence the next byte starts a new request
// - Failed addressed requests get an exception reply
// - Exception reply: address, function, error code, CRC
// - Unsupported function gives error code 01
// - Unknown register address or range gives error code 02
// - Unacceptable value or quantity gives error code 03
// - Busy device answers error code 06 without executing
// - At most 127 registers per request or reply
// - Response delay zero is immediate, else up to 100 units
// - Two-bit character format selects parity and stop bits; here it only sets frame-end silence for 10-bit (code 3) or 11-bit characters
// - Three-bit baud code, 9600 selected after reset
module mrs_engine
  import mrs_pkg::*;
#(
  parameter int CLK_HZ       = `MRS_CLK_HZ,       // System clock rate
  parameter int DLY_UNIT_CYC = `MRS_DLY_UNIT_CYC  // Cycles per delay unit
)
(
  input  wire logic        clk,            // System clock
  input  wire logic        reset,          // Async reset, high
  input  wire logic        cfg_we,         // Load configuration
  input  wire logic [7:0]  cfg_slave_addr, // Own address
  input  wire logic [2:0]  cfg_baud,       // Baud code
  input  wire logic [1:0]  cfg_fmt,        // Character format
  input  wire logic [6:0]  cfg_resp_delay, // Reply delay units
  input  wire logic        rx_valid,       // Received byte strobe
  input  wire logic [7:0]  rx_data,        // Received byte
  output logic             tx_valid,       // Transmit byte valid
  output logic      [7:0]  tx_data_ff,     // Transmit byte
  input  wire logic        tx_ready,       // Transmitter takes byte
  output logic             reg_req_ff,     // Register access pulse
  output logic             reg_wr_ff,      // Access is a write
  output logic      [15:0] reg_addr_ff,    // Register address
  output logic      [15:0] reg_wdata_ff,   // Write value
  input  wire logic        reg_ack,        // Access done
  input  wire logic [15:0] reg_rdata,      // Read value
  input  wire logic [1:0]  reg_status,     // Access result
  input  wire logic        dev_busy,       // Long operation running
  output logic             frame_drop_ff   // Frame discarded pulse
);

  // ----------------------------------------
  // Storage and state
  // ----------------------------------------
  logic [7:0]  frame_mem [0:`MRS_BUF_DEPTH-1];
  mrs_state_t  state_ff;
  mrs_state_t  nxt_state;
  logic [7:0]  own_addr_ff;
  logic [2:0]  baud_ff;
  logic [1:0]  fmt_ff;
  logic [6:0]  dly_cfg_ff;
  logic [8:0]  rx_cnt_ff;
  logic        rx_ovf_ff;
  logic [16:0] sil_div_ff;
  logic [6:0]  sil_cnt_ff;
  logic [6:0]  sil_lim;
  logic [7:0]  fn_ff;
  logic        bcast_ff;
  logic        exc_ff;
  logic [15:0] start_ff;
  logic [7:0]  count_ff;
  logic [7:0]  idx_ff;
  logic [8:0]  tx_len_ff;
  logic [8:0]  tx_idx_ff;
  logic [17:0] dly_div_ff;
  logic [6:0]  dly_cnt_ff;
  logic [15:0] crc;
  logic        crc_init;
  logic        crc_en;
  logic [7:0]  crc_data;
  logic [7:0]  req_addr;
  logic [7:0]  req_fn;
  logic [7:0]  req_bc;
  logic [15:0] req_start;
  logic [15:0] req_qty;
  logic [16:0] range_end;
  logic        fn_ok;
  logic        len_ok;
  logic        qty_bad;
  logic        range_bad;
  logic        frame_ok;
  logic [7:0]  chk_code;
  logic [7:0]  stat_code;
  logic [8:0]  rd_pos;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [16:0] half_bit_cyc(input logic [2:0] code);
    int rate;
    case (code)
      3'h0:    rate = `MRS_BAUD_0;
      3'h1:    rate = `MRS_BAUD_1;
      3'h2:    rate = `MRS_BAUD_2;
      3'h3:    rate = `MRS_BAUD_3;
      3'h4:    rate = `MRS_BAUD_4;
      3'h5:    rate = `MRS_BAUD_5;
      3'h6:    rate = `MRS_BAUD_6;
      default: rate = `MRS_BAUD_7;
    endcase
    half_bit_cyc = 17'(CLK_HZ / (2 * rate));
  endfunction

  function automatic logic [15:0] mem_word(input logic [8:0] i);
    mem_word = {frame_mem[i], frame_mem[i + 9'h001]};
  endfunction

  // ----------------------------------------
  // Configuration
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      own_addr_ff <= `MRS_ADDR_RST;
      baud_ff     <= `MRS_BAUD_RST;
      fmt_ff      <= `MRS_FMT_RST;
      dly_cfg_ff  <= `MRS_DLY_RST;
    end
    else if (cfg_we)
    begin
      own_addr_ff <= cfg_slave_addr;
      baud_ff     <= cfg_baud;
      fmt_ff      <= cfg_fmt;
      dly_cfg_ff  <= (cfg_resp_delay > `MRS_DLY_MAX) ? `MRS_DLY_MAX : cfg_resp_delay;
    end
  end

  // ----------------------------------------
  // Receive and frame-end silence
  // ----------------------------------------
  // Half-bit ticks: 3.5 characters of 10 or 11 bits
  assign sil_lim = (fmt_ff == `MRS_FMT_8N1) ? `MRS_SIL_HALF_10 : `MRS_SIL_HALF_11;

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      rx_cnt_ff  <= 9'h000;
      rx_ovf_ff  <= 1'b0;
      sil_div_ff <= 17'h0_0000;
      sil_cnt_ff <= 7'h00;
    end
    else if (state_ff == ST_IDLE)
    begin
      if (rx_valid)
      begin
        rx_cnt_ff  <= (rx_cnt_ff < `MRS_BUF_DEPTH) ? rx_cnt_ff + 9'h001 : rx_cnt_ff;
        rx_ovf_ff  <= rx_ovf_ff | (rx_cnt_ff == `MRS_BUF_DEPTH);
        sil_div_ff <= 17'h0_0000;
        sil_cnt_ff <= 7'h00;
      end
      else if (rx_cnt_ff != 9'h000 && sil_cnt_ff < sil_lim)
      begin
        if (sil_div_ff >= half_bit_cyc(baud_ff) - 17'h0_0001)
        begin
          sil_div_ff <= 17'h0_0000;
          sil_cnt_ff <= sil_cnt_ff + 7'h01;
        end
        else
          sil_div_ff <= sil_div_ff + 17'h0_0001;
      end
    end
    else if (state_ff == ST_CHECK)
    begin
      rx_cnt_ff  <= 9'h000;
      rx_ovf_ff  <= 1'b0;
      sil_div_ff <= 17'h0_0000;
      sil_cnt_ff <= 7'h00;
    end
  end

  // ----------------------------------------
  // Request checks
  // ----------------------------------------
  assign req_addr  = frame_mem[0];
  assign req_fn    = frame_mem[1];
  assign req_start = mem_word(9'h002);
  assign req_qty   = mem_word(9'h004);
  assign req_bc    = frame_mem[6];
  assign range_end = {1'b0, req_start} + {1'b0, req_qty};
  assign fn_ok     = (req_fn == `MRS_FN_READ) || (req_fn == `MRS_FN_WR1) || (req_fn == `MRS_FN_WRN);

  always_comb
  begin
    len_ok    = 1'b1;
    qty_bad   = 1'b0;
    range_bad = 1'b0;
    if (req_fn == `MRS_FN_READ)
    begin
      len_ok    = (rx_cnt_ff == `MRS_LEN_FIX);
      qty_bad   = (req_qty == 16'h0000) || (req_qty > `MRS_MAX_REGS);
      range_bad = (range_end > `MRS_RANGE_TOP);
    end
    else if (req_fn == `MRS_FN_WR1)
      len_ok = (rx_cnt_ff == `MRS_LEN_FIX);
    else if (req_fn == `MRS_FN_WRN)
    begin
      len_ok    = (rx_cnt_ff == {1'b0, req_bc} + `MRS_LEN_WRN_HDR);
      qty_bad   = (req_qty == 16'h0000) || (req_qty > `MRS_MAX_REGS)
                  || ({8'h00, req_bc} != {req_qty[14:0], 1'b0});
      range_bad = (range_end > `MRS_RANGE_TOP);
    end
  end

  assign frame_ok = (rx_cnt_ff >= `MRS_LEN_MIN) && !rx_ovf_ff && (crc == 16'h0000) && len_ok
                    && (req_addr == own_addr_ff || req_addr == `MRS_BCAST);

  always_comb
  begin
    chk_code = `MRS_EXC_NONE;
    if (!fn_ok)
      chk_code = `MRS_EXC_FUNC;
    else if (qty_bad)
      chk_code = `MRS_EXC_DATA;
    else if (range_bad)
      chk_code = `MRS_EXC_ADDR;
    else if (dev_busy)
      chk_code = `MRS_EXC_BUSY;
  end

  always_comb
  begin
    case (reg_status)
      RS_ADDR: stat_code = `MRS_EXC_ADDR;
      RS_DATA: stat_code = `MRS_EXC_DATA;
      default: stat_code = `MRS_EXC_BUSY;
    endcase
  end

  // ----------------------------------------
  // Sequencer
  // ----------------------------------------
  always_comb
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (rx_cnt_ff != 9'h000 && !rx_valid && sil_cnt_ff >= sil_lim)
          nxt_state = ST_CHECK;
      ST_CHECK:
        if (!frame_ok)
          nxt_state = ST_IDLE;
        else if (chk_code != `MRS_EXC_NONE)
          nxt_state = (req_addr == `MRS_BCAST) ? ST_IDLE : ST_DELAY;
        else
          nxt_state = ST_EXEC;
      ST_EXEC:
        nxt_state = ST_WAIT;
      ST_WAIT:
        if (reg_ack)
        begin
          if (reg_status != RS_OK || idx_ff == count_ff - 8'h01)
            nxt_state = bcast_ff ? ST_IDLE : ST_DELAY;
          else
            nxt_state = ST_EXEC;
        end
      ST_DELAY:
        if (dly_cnt_ff == 7'h00)
          nxt_state = ST_TXLD;
      ST_TXLD:
        nxt_state = ST_TX;
      ST_TX:
        if (tx_ready)
          nxt_state = (tx_idx_ff == tx_len_ff + 9'h001) ? ST_IDLE : ST_TXLD;
      default:
        nxt_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      state_ff <= ST_IDLE;
    else
      state_ff <= nxt_state;
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
      frame_drop_ff <= 1'b0;
    else
      frame_drop_ff <= (state_ff == ST_CHECK) && !frame_ok;
  end

  // ----------------------------------------
  // Request execution
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      fn_ff     <= 8'h00;
      bcast_ff  <= 1'b0;
      exc_ff    <= 1'b0;
      start_ff  <= 16'h0000;
      count_ff  <= 8'h00;
      idx_ff    <= 8'h00;
      tx_len_ff <= 9'h000;
    end
    else if (state_ff == ST_CHECK)
    begin
      fn_ff     <= req_fn;
      bcast_ff  <= (req_addr == `MRS_BCAST);
      exc_ff    <= (chk_code != `MRS_EXC_NONE);
      start_ff  <= req_start;
      count_ff  <= (req_fn == `MRS_FN_WR1) ? 8'h01 : req_qty[7:0];
      idx_ff    <= 8'h00;
      tx_len_ff <= `MRS_LEN_EXC;
    end
    else if (state_ff == ST_WAIT && reg_ack)
    begin
      idx_ff <= idx_ff + 8'h01;
      if (reg_status != RS_OK)
      begin
        exc_ff    <= 1'b1;
        tx_len_ff <= `MRS_LEN_EXC;
      end
      else if (fn_ff == `MRS_FN_READ)
        tx_len_ff <= `MRS_LEN_EXC + {count_ff, 1'b0};
      else
        tx_len_ff <= `MRS_LEN_ECHO;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      reg_req_ff   <= 1'b0;
      reg_wr_ff    <= 1'b0;
      reg_addr_ff  <= 16'h0000;
      reg_wdata_ff <= 16'h0000;
    end
    else
    begin
      reg_req_ff <= (state_ff == ST_EXEC);
      if (state_ff == ST_EXEC)
      begin
        reg_wr_ff    <= (fn_ff != `MRS_FN_READ);
        reg_addr_ff  <= start_ff + {8'h00, idx_ff};
        reg_wdata_ff <= (fn_ff == `MRS_FN_WR1) ? mem_word(9'h004)
                        : mem_word(9'h007 + {idx_ff, 1'b0});
      end
    end
  end

  // Frame buffer: request bytes, then reply bytes in place
  assign rd_pos = 9'h003 + {idx_ff, 1'b0};

  always_ff @(posedge clk)
  begin
    if (state_ff == ST_IDLE && rx_valid && rx_cnt_ff < `MRS_BUF_DEPTH)
      frame_mem[rx_cnt_ff] <= rx_data;
    if (state_ff == ST_CHECK && frame_ok && chk_code != `MRS_EXC_NONE)
      frame_mem[2] <= chk_code;
    if (state_ff == ST_WAIT && reg_ack)
    begin
      if (reg_status != RS_OK)
        frame_mem[2] <= stat_code;
      else if (fn_ff == `MRS_FN_READ)
      begin
        frame_mem[rd_pos]          <= reg_rdata[15:8];
        frame_mem[rd_pos + 9'h001] <= reg_rdata[7:0];
        frame_mem[2]               <= {count_ff[6:0], 1'b0};
      end
    end
  end

  // ----------------------------------------
  // Reply delay and transmit
  // ----------------------------------------
  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      dly_div_ff <= 18'h0_0000;
      dly_cnt_ff <= 7'h00;
    end
    else if (state_ff == ST_CHECK)
    begin
      dly_div_ff <= 18'h0_0000;
      dly_cnt_ff <= dly_cfg_ff;
    end
    else if (state_ff == ST_DELAY && dly_cnt_ff != 7'h00)
    begin
      if (dly_div_ff == 18'(DLY_UNIT_CYC - 1))
      begin
        dly_div_ff <= 18'h0_0000;
        dly_cnt_ff <= dly_cnt_ff - 7'h01;
      end
      else
        dly_div_ff <= dly_div_ff + 18'h0_0001;
    end
  end

  always_ff @(posedge clk or posedge reset)
  begin
    if (reset)
    begin
      tx_idx_ff  <= 9'h000;
      tx_data_ff <= 8'h00;
    end
    else if (state_ff == ST_DELAY)
      tx_idx_ff <= 9'h000;
    else if (state_ff == ST_TXLD)
    begin
      if (tx_idx_ff < tx_len_ff)
        tx_data_ff <= frame_mem[tx_idx_ff];
      else if (tx_idx_ff == tx_len_ff)
        tx_data_ff <= crc[7:0];
      else
        tx_data_ff <= crc[15:8];
    end
    else if (state_ff == ST_TX && tx_ready)
      tx_idx_ff <= tx_idx_ff + 9'h001;
  end

  assign tx_valid = (state_ff == ST_TX);

  // Shared CRC: receive check then reply generation
  assign crc_init = (state_ff == ST_IDLE && rx_cnt_ff == 9'h000) || (state_ff == ST_DELAY);
  assign crc_en   = (state_ff == ST_IDLE && rx_valid)
                    || (state_ff == ST_TX && tx_ready && tx_idx_ff < tx_len_ff);
  assign crc_data = (state_ff == ST_IDLE) ? rx_data : tx_data_ff;

  mrs_crc16 u_crc (
    .clk    (clk),
    .reset  (reset),
    .init   (crc_init),
    .en     (crc_en),
    .data   (crc_data),
    .crc_ff (crc)
  );

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  AST_NO_BCAST_REPLY:
  assert property (@(posedge clk) disable iff (reset) tx_valid |-> !bcast_ff)
    else $error("reply sent for broadcast");

  AST_ADDR_ECHO:
  assert property (@(posedge clk) disable iff (reset)
    (tx_valid && tx_idx_ff == 9'h000) |-> (tx_data_ff == own_addr_ff))
    else $error("reply address differs from request");

  AST_FN_SUPPORTED:
  assert property (@(posedge clk) disable iff (reset)
    reg_req_ff |-> (fn_ff == `MRS_FN_READ || fn_ff == `MRS_FN_WR1 || fn_ff == `MRS_FN_WRN))
    else $error("register access for unsupported function");

  AST_QTY_LIMIT:
  assert property (@(posedge clk) disable iff (reset)
    reg_req_ff |-> (count_ff != 8'h00 && count_ff <= 8'h7F && idx_ff < count_ff))
    else $error("register count out of range");

  AST_EXC_LEN:
  assert property (@(posedge clk) disable iff (reset)
    (tx_valid && exc_ff) |-> (tx_len_ff == `MRS_LEN_EXC))
    else $error("exception reply has wrong length");

  AST_CRC_LOW_FIRST:
  assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_TXLD && tx_idx_ff == tx_len_ff) |=> (tx_valid && tx_data_ff == $past(crc[7:0])))
    else $error("CRC low byte not sent first");

  AST_RD_BYTECOUNT:
  assert property (@(posedge clk) disable iff (reset)
    (tx_valid && tx_idx_ff == 9'h002 && fn_ff == `MRS_FN_READ && !exc_ff)
    |-> (tx_data_ff == {count_ff[6:0], 1'b0}))
    else $error("read byte count is not twice the register count");

  AST_DISCARD:
  assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_CHECK && !frame_ok) |=> (state_ff == ST_IDLE && frame_drop_ff) ##1 !tx_valid)
    else $error("bad frame not discarded");

  AST_BUSY_REJECT:
  assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_CHECK && frame_ok && fn_ok && !qty_bad && !range_bad && dev_busy)
    |=> (exc_ff && state_ff != ST_EXEC) ##1 !reg_req_ff)
    else $error("busy request was executed");

  AST_NO_DELAY:
  assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_DELAY && dly_cnt_ff == 7'h00) |=> ##1 tx_valid)
    else $error("zero delay reply not started at once");

  AST_REARM:
  assert property (@(posedge clk) disable iff (reset)
    (state_ff == ST_CHECK) |=> (rx_cnt_ff == 9'h000 && sil_cnt_ff == 7'h00))
    else $error("receiver not rearmed after frame end");

endmodule

// ===== test/mrs_master.sv
// Bus master model: sends request frames, collects reply bytes
`timescale 1ns/10ps
module mrs_master (
  input  wire logic       clk,        // System clock
  output logic            rx_valid,   // Byte strobe to engine
  output logic      [7:0] rx_data,    // Byte to engine
  input  wire logic       tx_valid,   // Reply byte valid
  input  wire logic [7:0] tx_data_ff, // Reply byte
  output logic            tx_ready,   // Takes reply byte
  input  wire logic       slow        // Stall every other cycle
);
  logic [7:0] rq[$];
  logic       tog;
  initial
  begin
    rx_valid = 1'b0;
    rx_data  = 8'h00;
    tog      = 1'b0;
  end
  assign tx_ready = !slow || tog;
  always @(posedge clk)
  begin
    tog <= ~tog;
    if (tx_valid && tx_ready) rq.push_back(tx_data_ff);
  end
  function automatic logic [15:0] crc(input logic [7:0] f[$]);
    logic [15:0] c;
    c = 16'hFFFF;
    foreach (f[i])
    begin
      c ^= {8'h00, f[i]};
      repeat (8) c = c[0] ? (c >> 1) ^ 16'hA001 : c >> 1;
    end
    return c;
  endfunction
  task automatic send(input logic [7:0] f[$]);
    logic [15:0] c;
    c = crc(f);
    f.push_back(c[7:0]);
    f.push_back(c[15:8]);
    foreach (f[i])
    begin
      @(posedge clk);
      rx_valid <= 1'b1;
      rx_data  <= f[i];
    end
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_data  <= ~rx_data;
  endtask
endmodule

// ===== test/mrs_engine_tb.sv
// Testbench for the serial register-protocol slave engine
`timescale 1ns/10ps
module mrs_engine_tb
  import mrs_pkg::*;
;
  logic clk, reset, cfg_we, rx_valid, tx_valid, tx_ready, reg_req_ff, reg_wr_ff, reg_ack, dev_busy, frame_drop_ff, slow;
  logic [7:0]  rx_data, tx_data_ff, cfg_slave_addr;
  logic [15:0] reg_addr_ff, reg_wdata_ff, reg_rdata, mem[4];
  logic [1:0]  reg_status, cfg_fmt;
  logic [6:0]  cfg_resp_delay;
  int          err_count, n_checks, cyc, drops, lat, lat_ref;
  // Delay unit in cycles; half-bit ticks at 115200 baud on a 1 MHz clock
  localparam int DLY_UNIT = 8;
  localparam int HALF_BIT = 4;
  mrs_engine #(.CLK_HZ(1000000), .DLY_UNIT_CYC(DLY_UNIT)) i_mrs_engine (.clk(clk), .reset(reset), .cfg_we(cfg_we),
    .cfg_slave_addr(cfg_slave_addr), .cfg_baud(3'h6), .cfg_fmt(cfg_fmt), .cfg_resp_delay(cfg_resp_delay),
    .rx_valid(rx_valid),
    .rx_data(rx_data), .tx_valid(tx_valid), .tx_data_ff(tx_data_ff), .tx_ready(tx_ready), .reg_req_ff(reg_req_ff),
    .reg_wr_ff(reg_wr_ff), .reg_addr_ff(reg_addr_ff), .reg_wdata_ff(reg_wdata_ff), .reg_ack(reg_ack),
    .reg_rdata(reg_rdata), .reg_status(reg_status), .dev_busy(dev_busy), .frame_drop_ff(frame_drop_ff));
  mrs_master i_mrs_master (.clk(clk), .rx_valid(rx_valid), .rx_data(rx_data), .tx_valid(tx_valid),
    .tx_data_ff(tx_data_ff), .tx_ready(tx_ready), .slow(slow));
  // --------------------------------
  // Register store and clock
  // --------------------------------
  assign reg_rdata  = mem[reg_addr_ff[1:0]];
  assign reg_status = (reg_addr_ff == 16'h0100) ? 2'h3 : 2'h0;
  always @(posedge clk)
  begin
    reg_ack <= reg_req_ff;
    if (reg_req_ff && reg_wr_ff) mem[reg_addr_ff[1:0]] <= reg_wdata_ff;
    if (frame_drop_ff) drops++;
    cyc++;
    if (cyc == 40000)
    begin
      err_count++;
      wrap_up();
    end
  end
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // --------------------------------
  // Tasks
  // --------------------------------
  task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
    n_checks++;
    if (s !== e)
    begin
      err_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic run(input string nm, input logic [7:0] f[$], input logic [7:0] e[$]);
    logic [15:0] c;
    i_mrs_master.rq = {};
    lat = 0;
    i_mrs_master.send(f);
    c = i_mrs_master.crc(e);
    if (e.size() > 0) e = {e, c[7:0], c[15:8]};
    for (int i = 0; i < 1500 && (e.size() == 0 || i_mrs_master.rq.size() < e.size()); i++)
    begin
      @(posedge clk);
      if (lat == 0 && i_mrs_master.rq.size() > 0) lat = i;
    end
    repeat (40) @(posedge clk);
    chk(nm, e.size(), i_mrs_master.rq.size());
    foreach (e[i]) chk(nm, e[i], i_mrs_master.rq[i]);
    $display("%s done", nm);
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // --------------------------------
  // Tests
  // --------------------------------
  initial
  begin
    {reset, cfg_we, dev_busy, slow, reg_ack, cfg_slave_addr} = {5'h10, 8'h00};
    cfg_fmt        = 2'h0;
    cfg_resp_delay = 7'h00;
    repeat (3) @(posedge clk);
    reset          <= 1'b0;
    cfg_we         <= 1'b1;
    cfg_slave_addr <= 8'hC3;
    @(posedge clk);
    cfg_we <= 1'b0;
    run("wr1", '{8'hC3, 8'h06, 8'hE0, 8'h01, 8'h12, 8'h34}, '{8'hC3, 8'h06, 8'hE0, 8'h01, 8'h12, 8'h34});
    lat_ref = lat;
    slow <= 1'b1;
    run("wrn", '{8'hC3, 8'h10, 8'hE0, 8'h01, 8'h00, 8'h03, 8'h06, 8'h00, 8'h01, 8'hAB, 8'hCD, 8'h56, 8'h78},
        '{8'hC3, 8'h10, 8'hE0, 8'h01, 8'h00, 8'h03});
    slow <= 1'b0;
    run("rd", '{8'hC3, 8'h03, 8'hE0, 8'h01, 8'h00, 8'h03},
        '{8'hC3, 8'h03, 8'h06, 8'h00, 8'h01, 8'hAB, 8'hCD, 8'h56, 8'h78});
    run("bcast", '{8'h00, 8'h06, 8'hE0, 8'h02, 8'h55, 8'hAA}, '{});
    run("other", '{8'h01, 8'h06, 8'hE0, 8'h03, 8'hFF, 8'hFF}, '{});
    run("rd2", '{8'hC3, 8'h03, 8'hE0, 8'h02, 8'h00, 8'h02},
        '{8'hC3, 8'h03, 8'h04, 8'h55, 8'hAA, 8'h56, 8'h78});
    run("fn", '{8'hC3, 8'h04, 8'h00, 8'h00, 8'h00, 8'h01}, '{8'hC3, 8'h04, 8'h01});
    run("qty", '{8'hC3, 8'h03, 8'h00, 8'h00, 8'h00, 8'h80}, '{8'hC3, 8'h03, 8'h03});
    run("range", '{8'hC3, 8'h03, 8'hFF, 8'hFF, 8'h00, 8'h02}, '{8'hC3, 8'h03, 8'h02});
    run("stat", '{8'hC3, 8'h03, 8'h01, 8'h00, 8'h00, 8'h01}, '{8'hC3, 8'h03, 8'h06});
    dev_busy <= 1'b1;
    run("busy", '{8'hC3, 8'h06, 8'hE0, 8'h01, 8'h00, 8'h00}, '{8'hC3, 8'h06, 8'h06});
    dev_busy <= 1'b0;
    run("len", '{8'hC3, 8'h06, 8'hE0, 8'h01, 8'h00, 8'h01, 8'h02}, '{});
    chk("drops", 16'h0002, 16'(drops));
    chk("mem1", 16'h0001, mem[1]);
    // Over-range delay is clamped to 100 units
    cfg_we         <= 1'b1;
    cfg_resp_delay <= 7'h7F;
    @(posedge clk);
    cfg_we <= 1'b0;
    run("dly", '{8'hC3, 8'h06, 8'hE0, 8'h00, 8'h00, 8'h07}, '{8'hC3, 8'h06, 8'hE0, 8'h00, 8'h00, 8'h07});
    chk("dly_lat", 16'(lat_ref + 100 * DLY_UNIT), 16'(lat));
    // Ten-bit characters shorten the frame-end silence
    cfg_we         <= 1'b1;
    cfg_resp_delay <= 7'h00;
    cfg_fmt        <= 2'h3;
    @(posedge clk);
    cfg_we <= 1'b0;
    run("fmt", '{8'hC3, 8'h06, 8'hE0, 8'h00, 8'h00, 8'h09}, '{8'hC3, 8'h06, 8'hE0, 8'h00, 8'h00, 8'h09});
    chk("fmt_lat", 16'(lat_ref - (77 - 70) * HALF_BIT), 16'(lat));
    wrap_up();
  end
endmodule
